// ===== src/torque_pkg.sv
// Constants and types shared by the torque-off and fault supervisor.
// =====================================================================
// Contract
// - With supervision on, the stage is on only while both inputs are high.
// - A self-check at power-on and on each both-high entry must pass.
// - Either safety input low disables all motor outputs at once.
// - Both low stops quietly, one high stops with a fault, both high enables.
// - Supervision is off unless the jumper strap shows removed.
// - Supervision on makes inputs three and four the safety pair only; REG_GPIN still returns both pins with supervision on.
// - Current over the limit for 1 to 65000 ms (500 default) is a stall.
// - A short circuit stops the drive until a zero command arrives.
// - Power ramps zero to full over 100 to 65000 ms, 500 by default.
// - Voltage limits step in 0.1 V, 60 V over and 5 V under by default.
// - Stall limit steps in 0.1 A and defaults to the top of its range.
// - The power LED is on steadily from power-on.
// - Status flashes repeat every 2 s; pattern and colour give the state.
package torque_pkg;
   // =================================================================
   // Timing
   localparam int CLK_PERIOD_NS = 8;
   localparam int CYC_PER_MS = 1000000 / CLK_PERIOD_NS;
   localparam int DEBOUNCE_NS = 1000;
   localparam int DEBOUNCE_CYC =
      (DEBOUNCE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CHECK_NS = 10000;
   localparam int CHECK_CYC = (CHECK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int LED_SLOT_MS = 250;
   localparam int PWR_FULL = 1000;
   // =================================================================
   // Register map
   localparam int ADR_W = 5;
   localparam logic [4:0] REG_CMD = 5'h00;
   localparam logic [4:0] REG_STALL_MS = 5'h04;
   localparam logic [4:0] REG_RAMP_MS = 5'h08;
   localparam logic [4:0] REG_OV_LIM = 5'h0c;
   localparam logic [4:0] REG_UV_LIM = 5'h10;
   localparam logic [4:0] REG_STALL_AMPS = 5'h14;
   localparam logic [4:0] REG_STATUS = 5'h18;
   localparam logic [4:0] REG_GPIN = 5'h1c;
   localparam logic [15:0] STALL_MS_RST = 16'h01f4;
   localparam logic [15:0] STALL_MS_MIN = 16'h0001;
   localparam logic [15:0] RAMP_MS_RST = 16'h01f4;
   localparam logic [15:0] RAMP_MS_MIN = 16'h0064;
   localparam logic [15:0] MS_MAX = 16'hfde8;
   localparam logic [15:0] OV_LIM_RST = 16'h0258;
   localparam logic [15:0] UV_LIM_RST = 16'h0032;
   localparam logic [15:0] STALL_AMPS_RST = 16'h012c;
   localparam logic [15:0] STALL_AMPS_MAX = 16'h012c;
   localparam logic [9:0] PWR_MAX = 10'h3e8;
   // =================================================================
   // Status bits
   localparam int ST_SUP = 0;
   localparam int ST_STAGE = 1;
   localparam int ST_PASS = 2;
   localparam int ST_MISMATCH = 3;
   localparam int ST_SHORT = 4;
   localparam int ST_STALL = 5;
   localparam int ST_OV = 6;
   localparam int ST_UV = 7;
   localparam int ST_FAIL = 8;
   // =================================================================
   // Flash patterns, one bit per 250 ms slot, first slot in bit 7
   localparam logic [7:0] LED_IDLE = 8'h80;
   localparam logic [7:0] LED_RUN = 8'ha0;
   localparam logic [7:0] LED_OFF_SAFE = 8'hc0;
   localparam logic [7:0] LED_MISMATCH = 8'haa;
   localparam logic [7:0] LED_SHORT = 8'h80;
   localparam logic [7:0] LED_STALL = 8'hc0;
   localparam logic [7:0] LED_VOLT = 8'he0;
   localparam logic [7:0] LED_CHKFAIL = 8'hf0;
   typedef enum logic [2:0] {
      CHK_WAIT = 3'b000,
      CHK_DRIVE = 3'b001,
      CHK_RELEASE = 3'b011,
      CHK_PASS = 3'b010,
      CHK_FAIL = 3'b110
   } chk_state_t;
endpackage : torque_pkg

// ===== src/input_filter.sv
// Two-flop synchronizer and debounce filter for pin inputs.
`timescale 1ns/1ps
`default_nettype none
module input_filter #(
   parameter int W = 1,
   parameter int DB_CYC = 1
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic [W-1:0] raw_in,
   output logic [W-1:0] sync_out,
   output logic [W-1:0] clean_out
);
   localparam int CW = $clog2(DB_CYC + 1);
   logic [W-1:0] meta_ff;
   logic [W-1:0] sync_ff;
   // =================================================================
   // Synchronizer
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         meta_ff <= '0;
         sync_ff <= '0;
      end
      else
      begin
         meta_ff <= raw_in;
         sync_ff <= meta_ff;
      end
   end
   assign sync_out = sync_ff;
   // =================================================================
   // Debounce: a level counts once it has stood DB_CYC cycles.
   for (genvar i = 0; i < W; i++)
   begin : g_bit
      logic [CW-1:0] cnt_ff;
      logic clean_ff;
      always_ff @(posedge ref_clk)
      begin
         if (srst)
         begin
            cnt_ff <= '0;
            clean_ff <= 1'b0;
         end
         else if (sync_ff[i] == clean_ff)
            cnt_ff <= '0;
         else if (cnt_ff == CW'(DB_CYC - 1))
         begin
            cnt_ff <= '0;
            clean_ff <= sync_ff[i];
         end
         else
            cnt_ff <= cnt_ff + 1'b1;
      end
      assign clean_out[i] = clean_ff;
   end
endmodule : input_filter
`default_nettype wire

// ===== src/span_timer.sv
// Millisecond span timer that reports when a condition has held long enough.
`timescale 1ns/1ps
`default_nettype none
module span_timer (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic run,
   input wire logic ms_tick,
   input wire logic [15:0] limit_ms,
   output logic expired
);
   logic [15:0] ms_ff;
   logic expired_ff;
   // =================================================================
   // Only a continuous span counts; the first tick may come 1 ms early.
   always_ff @(posedge ref_clk)
   begin
      if (srst || !run)
         ms_ff <= '0;
      else if (ms_tick && ms_ff < limit_ms)
         ms_ff <= ms_ff + 16'h0001;
   end
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         expired_ff <= 1'b0;
      else
         expired_ff <= run && (ms_ff >= limit_ms);
   end
   assign expired = expired_ff;
endmodule : span_timer
`default_nettype wire

// ===== src/torque_off_fault_supervisor.sv
// Torque-off supervision, fault stops, power ramp and status LEDs.
//
// Design decisions made here: the Wishbone register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module torque_off_fault_supervisor #(
   parameter int CYC_MS = torque_pkg::CYC_PER_MS
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [torque_pkg::ADR_W-1:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   input wire logic general_input_three,
   input wire logic general_input_four,
   input wire logic jumper_removed,
   input wire logic short_detect,
   input wire logic self_test_sense,
   input wire logic [15:0] motor_current,
   input wire logic [15:0] bus_voltage,
   output logic stage_enable,
   output logic [9:0] applied_power,
   output logic self_test_drive,
   output logic power_led,
   output logic status_led_red,
   output logic status_led_green,
   output logic user_input_three,
   output logic user_input_four
);
   import torque_pkg::*;

   localparam int MSW = $clog2(CYC_MS);
   localparam int STEP_RAW = CYC_MS / PWR_FULL;
   localparam int STEP_CYC = (STEP_RAW < 1) ? 1 : STEP_RAW;
   localparam int CKW = $clog2(CHECK_CYC);

   // =================================================================
   // Helpers
   function automatic logic [15:0] wr16(input logic [15:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] sel);
      logic [15:0] r;
      r = old;
      if (sel[0])
         r[7:0] = dat[7:0];
      if (sel[1])
         r[15:8] = dat[15:8];
      return r;
   endfunction : wr16

   function automatic logic [15:0] clamp16(input logic [15:0] v,
                                           input logic [15:0] lo,
                                           input logic [15:0] hi);
      logic [15:0] r;
      r = v;
      if (v < lo)
         r = lo;
      else if (v > hi)
         r = hi;
      return r;
   endfunction : clamp16

   // =================================================================
   // Pin inputs
   logic [4:0] pin_sync;
   logic [4:0] pin_clean;
   input_filter #(
      .W(5),
      .DB_CYC(DEBOUNCE_CYC)
   ) u_filter (
      .ref_clk(ref_clk),
      .srst(srst),
      .raw_in({self_test_sense, short_detect, jumper_removed,
               general_input_four, general_input_three}),
      .sync_out(pin_sync),
      .clean_out(pin_clean)
   );

   logic safe_a;
   logic safe_b;
   logic both_high;
   logic one_high;
   assign safe_a = pin_clean[0];
   assign safe_b = pin_clean[1];
   assign both_high = safe_a && safe_b;
   assign one_high = safe_a ^ safe_b;

   // =================================================================
   // Strap capture, a few cycles after reset once the synchronizer holds
   // a real pin level.
   logic [1:0] strap_cnt_ff;
   logic sup_en_ff;
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         strap_cnt_ff <= 2'h0;
         sup_en_ff <= 1'b0;
      end
      else if (strap_cnt_ff != 2'h3)
      begin
         strap_cnt_ff <= strap_cnt_ff + 2'h1;
         if (strap_cnt_ff == 2'h2)
            sup_en_ff <= pin_sync[2];
      end
   end

   // =================================================================
   // Self-check: drive the test path, expect it to follow both ways.
   chk_state_t chk_ff;
   chk_state_t nxt_chk;
   logic [CKW-1:0] chk_cnt_ff;
   logic por_ff;
   logic both_prev_ff;
   logic phase_end;
   logic pair_rise;
   assign phase_end = (chk_cnt_ff == CKW'(CHECK_CYC - 1));
   assign pair_rise = both_high && !both_prev_ff;

   always_comb
   begin
      nxt_chk = chk_ff;
      case (chk_ff)
         CHK_WAIT:
            if (por_ff || pair_rise)
               nxt_chk = CHK_DRIVE;
         CHK_DRIVE:
            if (phase_end)
               nxt_chk = pin_sync[4] ? CHK_RELEASE : CHK_FAIL;
         CHK_RELEASE:
            if (phase_end)
               nxt_chk = pin_sync[4] ? CHK_FAIL : CHK_PASS;
         CHK_PASS:
            if (!both_high)
               nxt_chk = CHK_WAIT;
         CHK_FAIL:
            if (pair_rise)
               nxt_chk = CHK_DRIVE;
         default:
            nxt_chk = CHK_WAIT;
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         chk_ff <= CHK_WAIT;
         chk_cnt_ff <= '0;
         por_ff <= 1'b1;
         both_prev_ff <= 1'b0;
      end
      else
      begin
         chk_ff <= nxt_chk;
         chk_cnt_ff <= (nxt_chk != chk_ff) ? '0 : chk_cnt_ff + 1'b1;
         if (chk_ff == CHK_DRIVE)
            por_ff <= 1'b0;
         both_prev_ff <= both_high;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
         self_test_drive <= 1'b0;
      else
         self_test_drive <= (nxt_chk == CHK_DRIVE);
   end

   // =================================================================
   // Mismatch fault: held while exactly one input is high, released as
   // soon as the pair agrees; agreement high then reruns the check.
   logic mismatch_ff;
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         mismatch_ff <= 1'b0;
      else if (one_high)
         mismatch_ff <= 1'b1;
      else
         mismatch_ff <= 1'b0;
   end

   // =================================================================
   // Configuration registers
   logic [9:0] cmd_ff;
   logic [15:0] stall_ms_ff;
   logic [15:0] ramp_ms_ff;
   logic [15:0] ov_lim_ff;
   logic [15:0] uv_lim_ff;
   logic [15:0] stall_amps_ff;
   logic ack_ff;
   logic wb_req;
   logic wb_wr;
   logic [15:0] cmd_wide;
   assign wb_req = wb_cyc_i && wb_stb_i && !ack_ff;
   assign wb_wr = wb_req && wb_we_i;
   assign cmd_wide = wr16({6'h00, cmd_ff}, wb_dat_i, wb_sel_i);

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         cmd_ff <= 10'h000;
         stall_ms_ff <= STALL_MS_RST;
         ramp_ms_ff <= RAMP_MS_RST;
         ov_lim_ff <= OV_LIM_RST;
         uv_lim_ff <= UV_LIM_RST;
         stall_amps_ff <= STALL_AMPS_RST;
      end
      else if (wb_wr)
      begin
         case (wb_adr_i)
            REG_CMD:
               cmd_ff <= 10'(clamp16(cmd_wide, 16'h0000,
                                 {6'h00, PWR_MAX}));
            REG_STALL_MS:
               stall_ms_ff <= clamp16(wr16(stall_ms_ff, wb_dat_i,
                  wb_sel_i), STALL_MS_MIN, MS_MAX);
            REG_RAMP_MS:
               ramp_ms_ff <= clamp16(wr16(ramp_ms_ff, wb_dat_i,
                  wb_sel_i), RAMP_MS_MIN, MS_MAX);
            REG_OV_LIM:
               ov_lim_ff <= wr16(ov_lim_ff, wb_dat_i, wb_sel_i);
            REG_UV_LIM:
               uv_lim_ff <= wr16(uv_lim_ff, wb_dat_i, wb_sel_i);
            REG_STALL_AMPS:
               stall_amps_ff <= clamp16(wr16(stall_amps_ff, wb_dat_i,
                  wb_sel_i), 16'h0000, STALL_AMPS_MAX);
            default:
               cmd_ff <= cmd_ff;
         endcase
      end
   end

   // =================================================================
   // Millisecond tick shared by the stall timer and the LED
   logic [MSW-1:0] ms_cnt_ff;
   logic ms_tick;
   assign ms_tick = (ms_cnt_ff == MSW'(CYC_MS - 1));
   always_ff @(posedge ref_clk)
   begin
      if (srst || ms_tick)
         ms_cnt_ff <= '0;
      else
         ms_cnt_ff <= ms_cnt_ff + 1'b1;
   end

   // =================================================================
   // Fault stops
   logic over_volt;
   logic under_volt;
   logic stall_run;
   logic stall_hit;
   logic short_lock_ff;
   logic stall_lock_ff;
   logic drive_on;
   assign over_volt = bus_voltage > ov_lim_ff;
   assign under_volt = bus_voltage < uv_lim_ff;
   assign stall_run = drive_on && (motor_current > stall_amps_ff);

   span_timer u_stall (
      .ref_clk(ref_clk),
      .srst(srst),
      .run(stall_run),
      .ms_tick(ms_tick),
      .limit_ms(stall_ms_ff),
      .expired(stall_hit)
   );

   // A new fault in the same cycle as a zero command wins over release.
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         short_lock_ff <= 1'b0;
         stall_lock_ff <= 1'b0;
      end
      else
      begin
         if (pin_sync[3])
            short_lock_ff <= 1'b1;
         else if (cmd_ff == 10'h000)
            short_lock_ff <= 1'b0;
         if (stall_hit)
            stall_lock_ff <= 1'b1;
         else if (cmd_ff == 10'h000)
            stall_lock_ff <= 1'b0;
      end
   end

   // =================================================================
   // Stage enable. The off path reads the synchronized pins directly,
   // skipping the debounce delay; only turning on waits for the filter.
   logic fast_off;
   logic sto_ok;
   assign fast_off = sup_en_ff && !(pin_sync[0] && pin_sync[1]);
   assign sto_ok = !sup_en_ff || (both_high && chk_ff == CHK_PASS);
   assign drive_on = sto_ok && !fast_off && !short_lock_ff &&
                     !pin_sync[3] && !stall_lock_ff &&
                     !over_volt && !under_volt;
   assign stage_enable = drive_on;

   // =================================================================
   // Power ramp: one unit of PWR_FULL per ramp_ms * STEP_CYC cycles.
   logic [9:0] pwr_ff;
   logic [23:0] ramp_cnt_ff;
   logic [23:0] step_lim;
   assign step_lim = 24'(ramp_ms_ff * STEP_CYC);
   always_ff @(posedge ref_clk)
   begin
      if (srst || !drive_on)
      begin
         pwr_ff <= 10'h000;
         ramp_cnt_ff <= 24'h000000;
      end
      else if (pwr_ff == cmd_ff)
         ramp_cnt_ff <= 24'h000000;
      else if (ramp_cnt_ff >= step_lim - 24'h000001)
      begin
         ramp_cnt_ff <= 24'h000000;
         if (pwr_ff < cmd_ff)
            pwr_ff <= pwr_ff + 10'h001;
         else
            pwr_ff <= pwr_ff - 10'h001;
      end
      else
         ramp_cnt_ff <= ramp_cnt_ff + 24'h000001;
   end
   assign applied_power = pwr_ff;

   // =================================================================
   // General inputs seen by the rest of the controller
   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         user_input_three <= 1'b0;
         user_input_four <= 1'b0;
      end
      else
      begin
         user_input_three <= !sup_en_ff && safe_a;
         user_input_four <= !sup_en_ff && safe_b;
      end
   end

   // =================================================================
   // LEDs: eight 250 ms slots make one two-second flash cycle.
   logic [7:0] slot_ms_ff;
   logic [2:0] slot_ff;
   logic [7:0] pattern;
   logic fault_any;
   assign fault_any = (sup_en_ff && (mismatch_ff || chk_ff == CHK_FAIL))
                      || short_lock_ff || stall_lock_ff
                      || over_volt || under_volt;

   always_comb
   begin
      if (sup_en_ff && mismatch_ff)
         pattern = LED_MISMATCH;
      else if (sup_en_ff && chk_ff == CHK_FAIL)
         pattern = LED_CHKFAIL;
      else if (short_lock_ff)
         pattern = LED_SHORT;
      else if (stall_lock_ff)
         pattern = LED_STALL;
      else if (over_volt || under_volt)
         pattern = LED_VOLT;
      else if (fast_off)
         pattern = LED_OFF_SAFE;
      else if (pwr_ff != 10'h000)
         pattern = LED_RUN;
      else
         pattern = LED_IDLE;
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         slot_ms_ff <= 8'h00;
         slot_ff <= 3'h0;
         power_led <= 1'b0;
         status_led_red <= 1'b0;
         status_led_green <= 1'b0;
      end
      else
      begin
         power_led <= 1'b1;
         if (ms_tick)
         begin
            if (slot_ms_ff == 8'(LED_SLOT_MS - 1))
            begin
               slot_ms_ff <= 8'h00;
               slot_ff <= slot_ff + 3'h1;
            end
            else
               slot_ms_ff <= slot_ms_ff + 8'h01;
         end
         status_led_red <= fault_any && pattern[3'h7 - slot_ff];
         status_led_green <= !fault_any && pattern[3'h7 - slot_ff];
      end
   end

   // =================================================================
   // Wishbone slave: ack one cycle after the request, reads registered.
   logic [15:0] status_word;
   always_comb
   begin
      status_word = 16'h0000;
      status_word[ST_SUP] = sup_en_ff;
      status_word[ST_STAGE] = drive_on;
      status_word[ST_PASS] = (chk_ff == CHK_PASS);
      status_word[ST_MISMATCH] = mismatch_ff;
      status_word[ST_SHORT] = short_lock_ff;
      status_word[ST_STALL] = stall_lock_ff;
      status_word[ST_OV] = over_volt;
      status_word[ST_UV] = under_volt;
      status_word[ST_FAIL] = (chk_ff == CHK_FAIL);
   end

   always_ff @(posedge ref_clk)
   begin
      if (srst)
      begin
         ack_ff <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end
      else
      begin
         ack_ff <= wb_req;
         if (wb_req && !wb_we_i)
         begin
            case (wb_adr_i)
               REG_CMD: wb_dat_o <= {22'h000000, cmd_ff};
               REG_STALL_MS: wb_dat_o <= {16'h0000, stall_ms_ff};
               REG_RAMP_MS: wb_dat_o <= {16'h0000, ramp_ms_ff};
               REG_OV_LIM: wb_dat_o <= {16'h0000, ov_lim_ff};
               REG_UV_LIM: wb_dat_o <= {16'h0000, uv_lim_ff};
               REG_STALL_AMPS: wb_dat_o <= {16'h0000, stall_amps_ff};
               REG_STATUS: wb_dat_o <= {6'h00, pwr_ff, status_word};
               REG_GPIN: wb_dat_o <= {30'h00000000, safe_b, safe_a};
               default: wb_dat_o <= 32'h00000000;
            endcase
         end
      end
   end
   assign wb_ack_o = ack_ff;
endmodule : torque_off_fault_supervisor
`default_nettype wire

// ===== tb/safety_partner.sv
// Safety switch pair and self-test readback path on the far side.
`timescale 1ns/1ps
`default_nettype none
module safety_partner (
   input wire logic ref_clk,
   input wire logic sw_a,
   input wire logic sw_b,
   input wire logic path_broken,
   input wire logic self_test_drive,
   output logic general_input_three,
   output logic general_input_four,
   output logic self_test_sense
);
   // A broken readback path reads stuck low, so the check must fail.
   always_ff @(posedge ref_clk)
      self_test_sense <= path_broken ? 1'b0 : self_test_drive;
   assign general_input_three = sw_a;
   assign general_input_four = sw_b;
endmodule : safety_partner
`default_nettype wire

// ===== tb/sup_checker.sv
// Port checker for the torque-off and fault supervisor.
`timescale 1ns/1ps
`default_nettype none
module sup_checker (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   input wire logic general_input_three,
   input wire logic general_input_four,
   input wire logic jumper_removed,
   input wire logic short_detect,
   input wire logic stage_enable,
   input wire logic [9:0] applied_power,
   input wire logic self_test_drive,
   input wire logic power_led,
   input wire logic user_input_three,
   input wire logic user_input_four
);
   // =================================================================
   // Helpers
   logic [2:0] up_ff;
   logic sup;
   always_ff @(posedge ref_clk)
   begin
      if (srst)
         up_ff <= 3'h0;
      else if (up_ff != 3'h7)
         up_ff <= up_ff + 3'h1;
   end
   assign sup = jumper_removed && (up_ff == 3'h7);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);
   // =================================================================
   // Properties
   AST_ACK_NEXT: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=>
      wb_ack_o) else $error("bus request not answered");
   AST_PAIR_LOW: assert property ((sup && (!general_input_three ||
      !general_input_four)) [*4] |-> !stage_enable)
      else $error("stage on with a safety input low");
   AST_CHECK_OFF: assert property (sup && self_test_drive |-> !stage_enable)
      else $error("stage on during self-check");
   AST_INPUTS_OUT: assert property (sup |-> !user_input_three &&
      !user_input_four) else $error("safety pins seen as user inputs");
   AST_POWER_LED: assert property (!srst |=> power_led)
      else $error("power led off");
   AST_RAMP_STEP: assert property (stage_enable && $past(stage_enable) |->
      applied_power <= $past(applied_power) + 10'h001)
      else $error("power jumped");
   AST_STOP_ZERO: assert property (!stage_enable [*2] |->
      applied_power == 10'h000) else $error("power while stage off");
   AST_SHORT_STOP: assert property (short_detect [*4] |-> ##[0:4]
      applied_power == 10'h000) else $error("power during short");
   COV_ENABLE: cover property ($rose(stage_enable));
   COV_SHORT: cover property (short_detect && stage_enable);
   COV_SPLIT: cover property (sup && general_input_three != general_input_four);
endmodule : sup_checker
bind torque_off_fault_supervisor sup_checker CHK (.*);
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the torque-off and fault supervisor.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import torque_pkg::*;
   logic ref_clk = 1'b0, srst = 1'b1, wb_cyc_i = 1'b0, wb_stb_i = 1'b0;
   logic wb_we_i = 1'b0, jumper_removed = 1'b0, short_detect = 1'b0;
   logic [4:0] wb_adr_i = 5'h00;
   logic [3:0] wb_sel_i = 4'h3;
   logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q, seed = 32'h47fe;
   logic [15:0] motor_current = 16'h0000, bus_voltage = 16'h00f0;
   logic [9:0] applied_power;
   logic wb_ack_o, general_input_three, general_input_four, self_test_sense;
   logic stage_enable, self_test_drive, power_led, status_led_red;
   logic status_led_green, user_input_three, user_input_four;
   logic sw_a = 1'b0, sw_b = 1'b0, broken = 1'b0;
   int error_cnt = 0, cmp_count = 0;
   torque_off_fault_supervisor #(.CYC_MS(1000)) DUT (.*);
   safety_partner PTR (.*, .path_broken(broken));
   initial forever #4 ref_clk = ~ref_clk;
   // =================================================================
   // Helpers
   function automatic logic [31:0] rnd();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   function automatic logic [31:0] rst_val(input logic [4:0] a);
      case (a)
         REG_STALL_MS: return STALL_MS_RST;
         REG_RAMP_MS: return RAMP_MS_RST;
         REG_OV_LIM: return OV_LIM_RST;
         REG_UV_LIM: return UV_LIM_RST;
         REG_STALL_AMPS: return STALL_AMPS_RST;
         default: return 32'h0;
      endcase
   endfunction : rst_val
   task automatic wt(input int n);
      repeat (n) @(posedge ref_clk);
   endtask : wt
   task automatic chk(input string nm, input logic [31:0] e, g);
      cmp_count++;
      if (g !== e)
      begin
         error_cnt++;
         $display("mismatch %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic bus(input logic we, input logic [4:0] a, input logic [31:0] d);
      int n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin @(posedge ref_clk); n++; end while (wb_ack_o !== 1'b1 && n < 40);
      q = wb_dat_o;
      chk("ack", 32'h1, wb_ack_o);
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge ref_clk);
   endtask : bus
   task automatic rd(input logic [4:0] a, input logic [31:0] e, input string nm);
      bus(1'b0, a, 32'h0);
      chk(nm, e, q);
   endtask : rd
   task automatic st(input int b, input logic e, input string nm);
      bus(1'b0, REG_STATUS, 32'h0);
      chk(nm, e, q[b]);
   endtask : st
   task automatic conclude();
      $display("checks %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : conclude
   // =================================================================
   // Tests
   initial
   begin
      logic [15:0] v;
      wt(2);
      srst <= 1'b0;
      wt(4);
      for (int i = 1; i < 6; i++) rd(5'(i * 4), rst_val(5'(i * 4)), "reset");
      rd(5'h03, 32'h0, "unmapped");
      chk("power led", 32'h1, power_led);
      v = 16'(rnd() % 65000 + 1);
      bus(1'b1, REG_STALL_MS, {16'h0, v});
      rd(REG_STALL_MS, {16'h0, v}, "stall time");
      st(ST_SUP, 1'b0, "supervision off");
      sw_a <= 1'b1;
      wt(300);
      chk("user input", 32'h1, user_input_three);
      $display("test defaults done");
      srst <= 1'b1;
      jumper_removed <= 1'b1;
      sw_b <= 1'b1;
      bus_voltage <= 16'(rnd() % 500 + 60);
      wt(2);
      srst <= 1'b0;
      wt(3000);
      chk("stage", 32'h1, stage_enable);
      chk("red led", 32'h0, status_led_red);
      chk("user inputs", 32'h0, {user_input_four, user_input_three});
      bus(1'b1, REG_RAMP_MS, 32'h64);
      bus(1'b1, REG_CMD, 32'h3e8);
      wt(600);
      chk("ramp", 32'h1, applied_power > 2 && applied_power < 8);
      sw_b <= 1'b0;
      wt(4);
      chk("stage", 32'h0, stage_enable);
      wt(200);
      st(ST_MISMATCH, 1'b1, "mismatch");
      chk("green led", 32'h0, status_led_green);
      sw_a <= 1'b0;
      wt(200);
      st(ST_MISMATCH, 1'b0, "mismatch");
      sw_a <= 1'b1;
      sw_b <= 1'b1;
      wt(200);
      chk("stage", 32'h0, stage_enable);
      wt(2800);
      chk("stage", 32'h1, stage_enable);
      $display("test safety pair done");
      short_detect <= 1'b1;
      wt(8);
      short_detect <= 1'b0;
      wt(8);
      st(ST_SHORT, 1'b1, "short lock");
      bus(1'b1, REG_CMD, 32'h3e8);
      wt(8);
      chk("power", 32'h0, applied_power);
      bus(1'b1, REG_CMD, 32'h0);
      wt(8);
      st(ST_SHORT, 1'b0, "short lock");
      bus(1'b1, REG_STALL_MS, 32'h1);
      bus(1'b1, REG_CMD, 32'h3e8);
      motor_current <= 16'(rnd() % 100 + 301);
      wt(2200);
      st(ST_STALL, 1'b1, "stall lock");
      motor_current <= 16'h0;
      bus(1'b1, REG_CMD, 32'h0);
      st(ST_STALL, 1'b0, "stall lock");
      $display("test faults done");
      broken <= 1'b1;
      sw_a <= 1'b0;
      wt(200);
      sw_a <= 1'b1;
      wt(3000);
      st(ST_FAIL, 1'b1, "check fail");
      chk("stage", 32'h0, stage_enable);
      $display("test check fail done");
      conclude();
   end
   initial
   begin
      wt(40000);
      error_cnt++;
      $display("mismatch watchdog expected end seen timeout");
      conclude();
   end
endmodule : testbench
`default_nettype wire
